//--- dbgctl_pkg.sv
// Shared constants and state types for the debugger control block.
// Assumes a single 125 MHz APB clock domain.
package dbgctl_pkg;

  localparam logic [11:0] ctl_offset = 12'h000;
  localparam logic [11:0] sts_offset = 12'h004;
  localparam logic [11:0] msk_offset = 12'h008;

  localparam logic [7:0] ctl_reset = 8'h00;
  localparam int halt_bit = 7;
  localparam int breakpoint_enable_bit = 6;
  localparam int ack_bit = 5;
  localparam int chip_reset_bit = 0;
  localparam logic [7:0] ctl_rw_mask = 8'hE1;

  localparam logic [7:0] reset_halt_cmd = 8'h81;
  localparam logic [7:0] reset_go_cmd = 8'h41;
  localparam logic [7:0] run_cmd = 8'h40;
  localparam logic [7:0] breakpoint_opcode = 8'h00;

  // Interrupt status layout
  localparam int ev_break = 0;
  localparam int ev_serial = 1;
  localparam int ev_chip_reset = 2;
  localparam int ev_width = 3;
  localparam logic [2:0] ev_reset = 3'h0;

  // Serial break: nine bit times at the slowest baud, clk/512
  localparam int break_bits = 9;
  localparam int min_baud_div = 512;
  localparam int break_cycles = break_bits * min_baud_div;
  localparam int low_cnt_w = 13;

  typedef struct packed {
    logic halt;
    logic breakpoint_enable;
    logic ack;
  } ctl_t;

  typedef struct packed {
    ctl_t ctl;
    logic [ev_width-1:0] sts;
    logic [ev_width-1:0] msk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic chip_reset;
    logic baud_reset;
    logic brk_nop;
    logic [low_cnt_w-1:0] low_cnt;
    logic in_break;
  } state_t;

endpackage

//--- dbgctl_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module dbgctl_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

//--- dbgctl.sv
// Debugger control register with APB access, breakpoint trap,
// chip reset commands and serial break watch on the debug pin.
// Assumes core decode and option inputs are on pclk.
// Operation
// - Writing 81H resets the chip and leaves it halted in debug mode
// - Writing 41H resets the chip and lets it run normally
// - Writing 40H while halted resumes execution
// - Halt flag at bit 7 set stops instruction fetch
// - Clearing the halt flag restarts instruction fetch
// - Opcode 00H decoded with breakpoints enabled sets the halt flag
// - With breakpoints disabled, opcode 00H acts as no-operation
// - Read protect blocks software clearing the halt flag; reset only
// - Halt flag 0 means normal operation, 1 means debug mode
// - Serial break resets baud detector, leaves control register alone
`timescale 1ns/1ns
module dbgctl #(
  parameter int BREAK_CYCLES = dbgctl_pkg::break_cycles
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic decode_valid,
  input wire logic [7:0] decode_opcode,
  input wire logic read_protect,
  input wire logic debug_serial_pin,
  output logic fetch_stop,
  output logic chip_reset_req,
  output logic baud_reset,
  output logic brk_nop,
  output logic irq
);
  // Last count of a low run before the pin counts as a break
  typedef logic [dbgctl_pkg::low_cnt_w-1:0] cnt_t;
  localparam cnt_t break_last = cnt_t'(BREAK_CYCLES - 1);
  dbgctl_pkg::state_t s_q;
  dbgctl_pkg::state_t s_d;
  logic pin_s;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] ctl_rd;
  logic [7:0] wbyte;
  logic brk_hit;
  logic [dbgctl_pkg::ev_width-1:0] ev;

  dbgctl_sync #(
    .RESET_VAL(1'b1)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(debug_serial_pin),
    .sync_out(pin_s)
  );

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && s_q.pready && pwrite;
  assign rd_acc = psel && penable && s_q.pready && !pwrite;
  assign wbyte = pwdata[7:0];
  // Reserved bits and the self-clearing reset bit read as zero
  assign ctl_rd = {s_q.ctl.halt, s_q.ctl.breakpoint_enable, s_q.ctl.ack, 5'h00};
  assign brk_hit = decode_valid &&
                   decode_opcode == dbgctl_pkg::breakpoint_opcode &&
                   s_q.ctl.breakpoint_enable;

  always_comb begin
    s_d = s_q;
    ev = dbgctl_pkg::ev_reset;
    s_d.chip_reset = 1'b0;
    s_d.baud_reset = 1'b0;
    // Disabled breakpoint is flagged to the core as a no-operation
    s_d.brk_nop = decode_valid && !s_q.ctl.breakpoint_enable &&
                  decode_opcode == dbgctl_pkg::breakpoint_opcode;

    // APB: registered answer, one wait-free access phase
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        dbgctl_pkg::ctl_offset: s_d.prdata = {24'h00_0000, ctl_rd};
        dbgctl_pkg::sts_offset: s_d.prdata = {29'h000_0000, s_q.sts};
        dbgctl_pkg::msk_offset: s_d.prdata = {29'h000_0000, s_q.msk};
        default: s_d.pslverr = 1'b1;
      endcase
    end

    if (wr_acc && !s_q.pslverr) begin
      case (paddr)
        dbgctl_pkg::ctl_offset: begin
          s_d.ctl.breakpoint_enable = wbyte[dbgctl_pkg::breakpoint_enable_bit];
          s_d.ctl.ack = wbyte[dbgctl_pkg::ack_bit];
          // Protected part: flag may be set but never cleared by writes
          if (wbyte[dbgctl_pkg::halt_bit] || !read_protect) begin
            s_d.ctl.halt = wbyte[dbgctl_pkg::halt_bit];
          end
          // Reset bit self-clears; halt flag survives the chip reset
          if (wbyte[dbgctl_pkg::chip_reset_bit]) begin
            s_d.chip_reset = 1'b1;
            ev[dbgctl_pkg::ev_chip_reset] = 1'b1;
          end
        end
        dbgctl_pkg::msk_offset: s_d.msk = wbyte[dbgctl_pkg::ev_width-1:0];
        default: ;
      endcase
    end

    if (brk_hit) begin
      s_d.ctl.halt = 1'b1;
      ev[dbgctl_pkg::ev_break] = 1'b1;
    end

    // Break watch: only the baud logic is reset, control is untouched
    if (pin_s) begin
      s_d.low_cnt = '0;
      s_d.in_break = 1'b0;
    end else if (!s_q.in_break) begin
      s_d.low_cnt = s_q.low_cnt + 1'b1;
      if (s_q.low_cnt == break_last) begin
        s_d.in_break = 1'b1;
        s_d.baud_reset = 1'b1;
        ev[dbgctl_pkg::ev_serial] = 1'b1;
      end
    end

    // Read clears only the bits the master saw; new events win
    if (rd_acc && paddr == dbgctl_pkg::sts_offset) begin
      s_d.sts = s_q.sts & ~s_q.prdata[dbgctl_pkg::ev_width-1:0];
    end
    s_d.sts = s_d.sts | ev;
    s_d.irq = |(s_d.sts & s_d.msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.ctl.halt <= dbgctl_pkg::ctl_reset[dbgctl_pkg::halt_bit];
      s_q.ctl.breakpoint_enable <= dbgctl_pkg::ctl_reset[dbgctl_pkg::breakpoint_enable_bit];
      s_q.ctl.ack <= dbgctl_pkg::ctl_reset[dbgctl_pkg::ack_bit];
      s_q.sts <= dbgctl_pkg::ev_reset;
      s_q.msk <= dbgctl_pkg::ev_reset;
      s_q.prdata <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.chip_reset <= 1'b0;
      s_q.baud_reset <= 1'b0;
      s_q.brk_nop <= 1'b0;
      s_q.low_cnt <= 13'h0000;
      s_q.in_break <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  // Flag 1 is debug mode and holds off fetch; 0 is normal run
  assign fetch_stop = s_q.ctl.halt;
  assign chip_reset_req = s_q.chip_reset;
  assign baud_reset = s_q.baud_reset;
  assign brk_nop = s_q.brk_nop;
  assign irq = s_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RESET_HALT: assert property (
    wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    wbyte == dbgctl_pkg::reset_halt_cmd && !brk_hit
    |=> chip_reset_req && fetch_stop && !s_q.ctl.breakpoint_enable &&
    s_q.sts[dbgctl_pkg::ev_chip_reset])
    else $error("81H did not reset and halt");

  AST_RESET_GO: assert property (
    wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    wbyte == dbgctl_pkg::reset_go_cmd && !brk_hit && !read_protect
    |=> chip_reset_req && !fetch_stop)
    else $error("41H did not reset and run");

  AST_RUN: assert property (
    fetch_stop && wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    wbyte == dbgctl_pkg::run_cmd && !read_protect && !brk_hit
    |=> !fetch_stop && !chip_reset_req)
    else $error("40H did not resume");

  AST_HALT_HOLDS: assert property (
    fetch_stop && !(wr_acc && paddr == dbgctl_pkg::ctl_offset)
    |=> fetch_stop)
    else $error("Halt dropped without a write");

  AST_CLEAR_RESTART: assert property (
    $fell(fetch_stop) |-> $past(wr_acc) && !$past(read_protect))
    else $error("Fetch restarted without an allowed clear");

  AST_BRK_SET: assert property (
    brk_hit |=> fetch_stop ##0 s_q.sts[dbgctl_pkg::ev_break])
    else $error("Breakpoint did not halt");

  AST_BRK_NOP: assert property (
    decode_valid && decode_opcode == dbgctl_pkg::breakpoint_opcode &&
    !s_q.ctl.breakpoint_enable && !fetch_stop && !wr_acc
    |=> brk_nop && !fetch_stop)
    else $error("Disabled breakpoint changed state");

  AST_PROTECT: assert property (
    read_protect && fetch_stop |=> fetch_stop)
    else $error("Protected halt flag was cleared");

  AST_BREAK_KEEPS_CTL: assert property (
    baud_reset && !$past(wr_acc) && !$past(brk_hit)
    |-> $stable(s_q.ctl))
    else $error("Serial break changed control");

  AST_RESERVED_ZERO: assert property (
    pready && paddr == dbgctl_pkg::ctl_offset && !pwrite
    |-> prdata[4:0] == 5'h00)
    else $error("Reserved bits not zero");

  AST_CLEAR_WRITE: assert property (
    fetch_stop && wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    !wbyte[dbgctl_pkg::halt_bit] && !read_protect && !brk_hit
    |=> !fetch_stop)
    else $error("Allowed clear did not restart fetch");

  // Debug mode is only ever entered by a trap or by software
  AST_RISE_CAUSE: assert property (
    $rose(fetch_stop) |-> $past(brk_hit) || ($past(wr_acc) &&
    $past(paddr) == dbgctl_pkg::ctl_offset &&
    $past(wbyte[dbgctl_pkg::halt_bit])))
    else $error("Debug mode entered without a cause");

  AST_RESET_EVENT: assert property (
    wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    wbyte[dbgctl_pkg::chip_reset_bit]
    |=> chip_reset_req && s_q.sts[dbgctl_pkg::ev_chip_reset])
    else $error("Reset command left no status event");

  AST_RESET_PULSE: assert property (
    chip_reset_req |=> !chip_reset_req)
    else $error("Chip reset request longer than one cycle");

  // Chip reset must not drop the halt, or reset-and-stop would run
  AST_HALT_SURVIVES: assert property (
    chip_reset_req && fetch_stop |=> fetch_stop)
    else $error("Chip reset request cleared the halt flag");

  AST_RUN_ARMS: assert property (
    wr_acc && paddr == dbgctl_pkg::ctl_offset &&
    wbyte == dbgctl_pkg::run_cmd
    |=> s_q.ctl.breakpoint_enable && !chip_reset_req)
    else $error("40H did not leave breakpoints armed");

  // Break detection fires once per low run, then waits for idle
  AST_BAUD_PULSE: assert property (
    baud_reset |-> !$past(pin_s) && s_q.in_break ##1 !baud_reset)
    else $error("Baud reset without a full low run");

  AST_LOW_RUN: assert property (
    s_q.low_cnt != '0 |-> !$past(pin_s))
    else $error("Low run counted while the pin was high");

  AST_BREAK_REARM: assert property (
    pin_s |=> s_q.low_cnt == '0 && !s_q.in_break)
    else $error("Break watch not rearmed on idle pin");

  AST_SERIAL_EVENT: assert property (
    baud_reset |-> s_q.sts[dbgctl_pkg::ev_serial])
    else $error("Serial break left no status event");

  AST_NOP_ONLY_DISABLED: assert property (
    brk_nop |-> !$past(s_q.ctl.breakpoint_enable) && $past(decode_valid))
    else $error("No-operation flagged with breakpoints enabled");

  AST_PROTECT_WRITE: assert property (
    read_protect && fetch_stop && wr_acc &&
    paddr == dbgctl_pkg::ctl_offset && !wbyte[dbgctl_pkg::halt_bit]
    |=> fetch_stop)
    else $error("Protected write of 0 cleared the halt flag");

  // Status is sticky: only the read that returned a bit clears it
  AST_BRK_STICKY: assert property (
    s_q.sts[dbgctl_pkg::ev_break] &&
    !(rd_acc && paddr == dbgctl_pkg::sts_offset)
    |=> s_q.sts[dbgctl_pkg::ev_break])
    else $error("Breakpoint event lost before a status read");

  AST_ACK_STORE: assert property (
    wr_acc && paddr == dbgctl_pkg::ctl_offset
    |=> s_q.ctl.ack == $past(wbyte[dbgctl_pkg::ack_bit]))
    else $error("Acknowledge bit did not take the written value");

  AST_UPPER_ZERO: assert property (
    pready && !pslverr |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper read data not zero");

  COV_RESET_HALT: cover property (chip_reset_req && fetch_stop);
  COV_BRK: cover property (brk_hit ##1 fetch_stop ##[1:20] !fetch_stop);
  COV_SERIAL: cover property (baud_reset ##[1:5] irq);
  COV_PROTECT: cover property (read_protect && fetch_stop && wr_acc);
  COV_NOP: cover property (brk_nop);
endmodule

//--- dbgctl_host.sv
// Host debugger model on the serial debug pin.
// Assumes the pin has a pull-up, so a released line reads high.
`timescale 1ns/1ns
module dbgctl_host #(
  parameter int LOW_CYCLES = 24
) (
  input wire logic pclk,
  input wire logic send_break,
  output logic pin
);
  int left = 0;
  assign pin = (left > 0) ? 1'b0 : 1'b1;
  always @(posedge pclk) begin
    if (send_break && left == 0) begin
      left <= LOW_CYCLES;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the debugger control block.
// Assumes dbgctl_pkg, dbgctl and dbgctl_host are compiled first.
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, decode_valid, read_protect;
  logic send_break, pin, pready, pslverr, fetch_stop, chip_reset_req;
  logic baud_reset, brk_nop, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s, r;
  logic [7:0] decode_opcode, ctl_m;
  logic [2:0] sts_m, msk_m;
  logic e;
  int n_errors, n_compared, nr, nb, nn, er, eb, en;
  dbgctl #(.BREAK_CYCLES(16)) dbgctl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .decode_valid(decode_valid), .decode_opcode(decode_opcode),
    .read_protect(read_protect), .debug_serial_pin(pin),
    .fetch_stop(fetch_stop), .chip_reset_req(chip_reset_req),
    .baud_reset(baud_reset), .brk_nop(brk_nop), .irq(irq));
  dbgctl_host dbgctl_host_i (.pclk(pclk), .send_break(send_break),
    .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge pclk) begin
    if (chip_reset_req === 1'b1) nr++;
    if (baud_reset === 1'b1) nb++;
    if (brk_nop === 1'b1) nn++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_errors++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk("prdata", x, r);
  endtask
  task automatic wctl(input logic [7:0] d);
    xfer(1'b1, dbgctl_pkg::ctl_offset, {24'h0, d});
    ctl_m = {read_protect ? ctl_m[7] | d[7] : d[7], d[6:5], 5'h0};
    if (d[0]) begin
      er++;
      sts_m[2] = 1'b1;
    end
  endtask
  task automatic op(input logic [7:0] o);
    @(posedge pclk);
    decode_valid <= 1'b1;
    decode_opcode <= o;
    @(posedge pclk);
    decode_valid <= 1'b0;
    if (o == 8'h00 && ctl_m[6]) begin
      ctl_m[7] = 1'b1;
      sts_m[0] = 1'b1;
    end else if (o == 8'h00) begin
      en++;
    end
  endtask
  task automatic look(input string t);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("fetch_stop", {31'h0, ctl_m[7]}, {31'h0, fetch_stop});
    chk("irq", {31'h0, |(sts_m & msk_m)}, {31'h0, irq});
    chk("chip resets", er, nr);
    chk("baud resets", eb, nb);
    chk("nops", en, nn);
    $display("test %s done", t);
  endtask
  task automatic rsts;
    rd(dbgctl_pkg::sts_offset, {29'h0, sts_m});
    sts_m = 3'h0;
  endtask
  initial begin
    {psel, penable, pwrite, decode_valid, read_protect, send_break} = 6'h0;
    {paddr, pwdata, decode_opcode} = 52'h0;
    {ctl_m, sts_m, msk_m, n_errors, n_compared} = 0;
    {nr, nb, nn, er, eb, en} = 0;
    s = 32'h0150_eea8;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(dbgctl_pkg::ctl_offset, 32'h0);
    rsts();
    rd(dbgctl_pkg::msk_offset, 32'h0);
    xfer(1'b0, 12'h00C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    xfer(1'b1, dbgctl_pkg::msk_offset, 32'h7);
    msk_m = 3'h7;
    wctl(8'h81);
    look("reset and halt");
    rd(dbgctl_pkg::ctl_offset, {24'h0, ctl_m});
    wctl(8'h40);
    look("run");
    wctl(8'h41);
    look("reset and go");
    rsts();
    wctl(8'h00);
    op(8'h00);
    look("breakpoint off");
    wctl(8'h40);
    op(8'h3C);
    op(8'h00);
    look("breakpoint on");
    rsts();
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      wctl(s[7:0]);
      look("random write");
      rd(dbgctl_pkg::ctl_offset, {24'h0, ctl_m});
    end
    rsts();
    read_protect <= 1'b1;
    wctl(8'h80);
    wctl(8'h40);
    look("read protect");
    @(posedge pclk);
    send_break <= 1'b1;
    @(posedge pclk);
    send_break <= 1'b0;
    repeat (40) @(posedge pclk);
    eb++;
    sts_m[1] = 1'b1;
    look("serial break");
    rd(dbgctl_pkg::ctl_offset, {24'h0, ctl_m});
    rsts();
    xfer(1'b1, dbgctl_pkg::msk_offset, 32'h0);
    msk_m = 3'h0;
    wctl(8'hC1);
    look("masked");
    rd(dbgctl_pkg::msk_offset, 32'h0);
    presetn <= 1'b0;
    read_protect <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {ctl_m, sts_m, msk_m} = 14'h0;
    look("second reset");
    rd(dbgctl_pkg::ctl_offset, 32'h0);
    close_out();
  end
endmodule
